// ===== rtl/bwm_pkg.sv
// Constants for the bandwidth monitor filter and selector bank
`default_nettype none
package bwm_pkg;
   // Offsets within each feature page
   localparam logic [11:0] OFS_SELECTOR = 12'h0800;
   localparam logic [11:0] OFS_FILTER = 12'h0820;
   localparam logic [11:0] OFS_CONTROL = 12'h0828;
   // Security address spaces
   localparam logic [1:0] SPACE_SECURE = 2'h0;
   localparam logic [1:0] SPACE_NONSECURE = 2'h1;
   localparam logic [1:0] SPACE_ROOT = 2'h2;
   localparam logic [1:0] SPACE_REALM = 2'h3;
   localparam int NUM_SPACES = 4;
   // Read/write filter codes
   localparam logic [1:0] RW_BOTH = 2'h0;
   localparam logic [1:0] RW_WRITE_ONLY = 2'h1;
   localparam logic [1:0] RW_READ_ONLY = 2'h2;
   // Filter field positions
   localparam int FLT_RW_LSB = 30;
   localparam int FLT_GROUP_LSB = 16;
   localparam int FLT_PART_LSB = 0;
   // Writable bit masks
   localparam logic [31:0] FLT_MASK_RW = 32'hC0FF_FFFF;
   localparam logic [31:0] FLT_MASK_NO_RW = 32'h00FF_FFFF;
   localparam logic [31:0] SEL_MASK_RES = 32'h0F00_FFFF;
   localparam logic [31:0] SEL_MASK_NO_RES = 32'h0000_FFFF;
   // Selector and control field positions
   localparam int SEL_RES_LSB = 24;
   localparam int SEL_MON_LSB = 0;
   localparam int CTL_MATCH_GROUP_BIT = 17;
   localparam int CTL_MATCH_PART_BIT = 16;
   // Values after reset
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage
`default_nettype wire

// ===== rtl/bwm_filter_bank.sv
// Banked bandwidth monitor filter, selector and match logic
`timescale 1ns/10ps
`default_nettype none
module bwm_filter_bank #(
   parameter int MONITOR_COUNT = 4,
   parameter int RESOURCE_COUNT = 2,
   parameter bit HAS_RW_FILTER = 1'b1,
   parameter bit HAS_RES_SELECT = 1'b1,
   parameter bit HAS_MONITORING = 1'b1,
   parameter bit HAS_BW_USAGE = 1'b1,
   parameter bit HAS_REALM_EXT = 1'b1
) (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic REQ,
   input wire logic REQ_WE,
   input wire logic [1:0] REQ_SPACE,
   input wire logic [11:0] REQ_ADDR,
   input wire logic [31:0] REQ_WDATA,
   output var logic RSP_VALID,
   output var logic [31:0] RSP_DATA,
   output var logic RSP_ERR,
   input wire logic TXN_VALID,
   input wire logic [1:0] TXN_SPACE,
   input wire logic TXN_IS_WRITE,
   input wire logic [15:0] TXN_PARTITION_ID,
   input wire logic [7:0] TXN_PERF_GROUP,
   output var logic [4*MONITOR_COUNT*RESOURCE_COUNT-1:0] MON_HIT
);
   import bwm_pkg::*;

   localparam int NSLOT = MONITOR_COUNT * RESOURCE_COUNT;
   localparam int IW = (NSLOT > 1) ? $clog2(NSLOT) : 1;
   localparam logic [31:0] FLT_MASK =
      HAS_RW_FILTER ? FLT_MASK_RW : FLT_MASK_NO_RW;
   localparam logic [31:0] SEL_MASK =
      HAS_RES_SELECT ? SEL_MASK_RES : SEL_MASK_NO_RES;

   typedef struct packed {
      logic [NUM_SPACES-1:0][NSLOT-1:0][31:0] flt;
      logic [NUM_SPACES-1:0][NSLOT-1:0] mge;
      logic [NUM_SPACES-1:0][NSLOT-1:0] mpe;
      logic [NUM_SPACES-1:0][31:0] sel;
      logic [31:0] rdata;
      logic rvalid;
      logic err;
      logic [4*NSLOT-1:0] hit;
   } bwm_state_t;

   bwm_state_t s_r;
   bwm_state_t s_nxt;

   // Resource instance from a selector word, zero when not built
   function automatic logic [3:0] sel_res(input logic [31:0] sel);
      return HAS_RES_SELECT ? sel[SEL_RES_LSB +: 4] : 4'h0;
   endfunction

   // Flat slot of the monitor that a selector word points at
   function automatic logic [IW-1:0] slot_of(input logic [31:0] sel);
      int v;
      v = int'(sel_res(sel)) * MONITOR_COUNT + int'(sel[SEL_MON_LSB +: 16]);
      return IW'(v);
   endfunction

   // Selector points past the monitors or resources that exist
   function automatic logic sel_oob(input logic [31:0] sel);
      return (int'(sel[SEL_MON_LSB +: 16]) >= MONITOR_COUNT) ||
             (int'(sel_res(sel)) >= RESOURCE_COUNT);
   endfunction

   // Whether a transaction passes one monitor's filter
   function automatic logic filt_pass(input logic [31:0] flt,
                                      input logic mge, input logic mpe,
                                      input logic is_wr,
                                      input logic [15:0] part,
                                      input logic [7:0] grp);
      logic [1:0] rw;
      logic rw_ok;
      rw = HAS_RW_FILTER ? flt[FLT_RW_LSB +: 2] : RW_BOTH;
      case (rw)
         RW_BOTH: rw_ok = 1'b1;
         RW_WRITE_ONLY: rw_ok = is_wr;
         RW_READ_ONLY: rw_ok = !is_wr;
         default: rw_ok = 1'b0;
      endcase
      return rw_ok &&
         (!mge || grp == flt[FLT_GROUP_LSB +: 8]) &&
         (!mpe || part == flt[FLT_PART_LSB +: 16]);
   endfunction

   logic [31:0] cur_sel;
   logic [IW-1:0] cur_slot;
   logic cur_oob;
   logic page_ok;
   logic usage_ok;

   always_comb begin
      cur_sel = s_r.sel[REQ_SPACE];
      cur_slot = slot_of(cur_sel);
      cur_oob = sel_oob(cur_sel);
      // root page only with realm extension
      page_ok = HAS_MONITORING && (REQ_SPACE != SPACE_ROOT || HAS_REALM_EXT);
      // filter and control exist only with bandwidth usage
      usage_ok = page_ok && HAS_BW_USAGE;
   end

   always_comb begin
      s_nxt = s_r;
      s_nxt.rvalid = REQ;
      s_nxt.rdata = RESET_WORD;
      s_nxt.err = 1'b0;
      if (REQ) begin
         case (REQ_ADDR)
            OFS_SELECTOR: begin
               if (page_ok) begin
                  if (REQ_WE) begin
                     s_nxt.sel[REQ_SPACE] = REQ_WDATA & SEL_MASK;
                  end else begin
                     s_nxt.rdata = cur_sel;
                  end
               end
            end
            OFS_FILTER: begin
               if (usage_ok && cur_oob) begin
                  s_nxt.err = 1'b1;
               end else if (usage_ok) begin
                  if (REQ_WE) begin
                     s_nxt.flt[REQ_SPACE][cur_slot] = REQ_WDATA & FLT_MASK;
                  end else begin
                     s_nxt.rdata = s_r.flt[REQ_SPACE][cur_slot];
                  end
               end
            end
            OFS_CONTROL: begin
               if (usage_ok && cur_oob) begin
                  s_nxt.err = 1'b1;
               end else if (usage_ok) begin
                  if (REQ_WE) begin
                     s_nxt.mge[REQ_SPACE][cur_slot] =
                        REQ_WDATA[CTL_MATCH_GROUP_BIT];
                     s_nxt.mpe[REQ_SPACE][cur_slot] =
                        REQ_WDATA[CTL_MATCH_PART_BIT];
                  end else begin
                     s_nxt.rdata[CTL_MATCH_GROUP_BIT] =
                        s_r.mge[REQ_SPACE][cur_slot];
                     s_nxt.rdata[CTL_MATCH_PART_BIT] =
                        s_r.mpe[REQ_SPACE][cur_slot];
                  end
               end
            end
            default: begin
               s_nxt.rdata = RESET_WORD;
            end
         endcase
      end
      for (int k = 0; k < 4 * NSLOT; k++) begin
         s_nxt.hit[k] = TXN_VALID && (k / NSLOT == int'(TXN_SPACE)) &&
            filt_pass(s_r.flt[k / NSLOT][k % NSLOT],
                      s_r.mge[k / NSLOT][k % NSLOT],
                      s_r.mpe[k / NSLOT][k % NSLOT],
                      TXN_IS_WRITE, TXN_PARTITION_ID, TXN_PERF_GROUP);
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign RSP_VALID = s_r.rvalid;
   assign RSP_DATA = s_r.rdata;
   assign RSP_ERR = s_r.err;
   assign MON_HIT = s_r.hit;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!NRST);

   // Filter write that lands in a live slot
   sequence s_flt_write;
      REQ && REQ_WE && REQ_ADDR == OFS_FILTER && usage_ok && !cur_oob;
   endsequence

   // Filter read of the same slot one cycle later
   sequence s_flt_read_same;
      REQ && !REQ_WE && REQ_ADDR == OFS_FILTER &&
         $stable(REQ_SPACE) && $stable(cur_sel);
   endsequence

   // Selector write on a live page
   sequence s_sel_write;
      REQ && REQ_WE && REQ_ADDR == OFS_SELECTOR && page_ok;
   endsequence

   // Selector read of the same page one cycle later
   sequence s_sel_read_same;
      REQ && !REQ_WE && REQ_ADDR == OFS_SELECTOR && $stable(REQ_SPACE);
   endsequence

   // Control write that lands in a live slot
   sequence s_ctl_write;
      REQ && REQ_WE && REQ_ADDR == OFS_CONTROL && usage_ok && !cur_oob;
   endsequence

   // Control read of the same slot one cycle later
   sequence s_ctl_read_same;
      REQ && !REQ_WE && REQ_ADDR == OFS_CONTROL &&
         $stable(REQ_SPACE) && $stable(cur_sel);
   endsequence

   // Answer one edge after every request
   a_resp_timing: assert property (REQ |=> RSP_VALID)
      else $error("answer did not follow request");

   // No answer without a request
   a_resp_idle: assert property (!REQ |=> !RSP_VALID && !RSP_ERR)
      else $error("answer without request");

   // Written filter bits come back masked
   a_filter_readback: assert property (
      s_flt_write ##1 s_flt_read_same
      |=> RSP_DATA == ($past(REQ_WDATA, 2) & FLT_MASK))
      else $error("filter readback wrong");

   // Written selector fields come back masked
   a_sel_readback: assert property (
      s_sel_write ##1 s_sel_read_same
      |=> RSP_DATA == ($past(REQ_WDATA, 2) & SEL_MASK))
      else $error("selector readback wrong");

   // Only the two match enables come back
   a_ctl_readback: assert property (
      s_ctl_write ##1 s_ctl_read_same
      |=> RSP_DATA == ($past(REQ_WDATA, 2) & 32'h0003_0000))
      else $error("control readback wrong");

   // Index past the built monitors
   a_oob_error: assert property (
      REQ && REQ_ADDR == OFS_FILTER && usage_ok && cur_oob
      |=> RSP_ERR && RSP_DATA == 32'h0000_0000)
      else $error("out of range index not flagged");

   // Unmapped offsets read zero quietly
   a_unmapped_zero: assert property (
      REQ && REQ_ADDR != OFS_SELECTOR && REQ_ADDR != OFS_FILTER &&
      REQ_ADDR != OFS_CONTROL |=> !RSP_ERR && RSP_DATA == 32'h0000_0000)
      else $error("unmapped offset not zero");

   // Root page empty without realm extension
   a_root_absent: assert property (
      REQ && REQ_SPACE == SPACE_ROOT && !HAS_REALM_EXT
      |=> !RSP_ERR && RSP_DATA == 32'h0000_0000)
      else $error("root page not read as zero");

   // Reserved middle bits always zero
   a_reserved_zero: assert property (
      RSP_VALID && !RSP_ERR && $past(REQ_ADDR) == OFS_FILTER
      |-> RSP_DATA[29:24] == 6'h00)
      else $error("reserved filter bits not zero");

   // Top byte zero without read/write filter
   a_rw_absent: assert property (
      RSP_VALID && !HAS_RW_FILTER && $past(REQ_ADDR) == OFS_FILTER
      |-> RSP_DATA[31:24] == 8'h00)
      else $error("top filter byte not zero");

   // Other pages leave the secure selector alone
   a_sel_banked: assert property (
      REQ && REQ_WE && REQ_ADDR == OFS_SELECTOR
      |=> $stable(s_r.sel[SPACE_SECURE]) ||
      $past(REQ_SPACE) == SPACE_SECURE)
      else $error("secure selector changed by other page");

   // No hits without traffic
   a_hit_idle: assert property (!TXN_VALID |=> MON_HIT == '0)
      else $error("hit without traffic");

   // Traffic of other spaces never hits the secure slots
   a_other_space: assert property (
      TXN_VALID && TXN_SPACE != SPACE_SECURE |=> MON_HIT[NSLOT-1:0] == '0)
      else $error("traffic hit another space");

   // Match checks for every slot of every space
   for (genvar k = 0; k < 4 * NSLOT; k++) begin : g_hit
      localparam int SP = k / NSLOT;
      localparam int SL = k % NSLOT;
      logic [31:0] f;
      assign f = s_r.flt[SP][SL];

      // Read traffic skips a write-only filter
      a_write_only: assert property (
         TXN_VALID && int'(TXN_SPACE) == SP && !TXN_IS_WRITE &&
         HAS_RW_FILTER && f[FLT_RW_LSB +: 2] == RW_WRITE_ONLY
         |=> !MON_HIT[k])
         else $error("read counted by write-only monitor");

      // Write traffic skips a read-only filter
      a_read_only: assert property (
         TXN_VALID && int'(TXN_SPACE) == SP && TXN_IS_WRITE &&
         HAS_RW_FILTER && f[FLT_RW_LSB +: 2] == RW_READ_ONLY
         |=> !MON_HIT[k])
         else $error("write counted by read-only monitor");

      // Reserved filter code matches nothing
      a_code_reserved: assert property (
         TXN_VALID && int'(TXN_SPACE) == SP &&
         HAS_RW_FILTER && f[FLT_RW_LSB +: 2] == 2'h3 |=> !MON_HIT[k])
         else $error("reserved code counted");

      // Partition mismatch never counted
      a_part_mismatch: assert property (
         TXN_VALID && int'(TXN_SPACE) == SP && s_r.mpe[SP][SL] &&
         TXN_PARTITION_ID != f[15:0] |=> !MON_HIT[k])
         else $error("partition mismatch counted");

      // Group mismatch never counted
      a_group_mismatch: assert property (
         TXN_VALID && int'(TXN_SPACE) == SP && s_r.mge[SP][SL] &&
         TXN_PERF_GROUP != f[23:16] |=> !MON_HIT[k])
         else $error("group mismatch counted");

      // No match enables: any label counts
      a_unfiltered: assert property (
         TXN_VALID && int'(TXN_SPACE) == SP && !s_r.mge[SP][SL] &&
         !s_r.mpe[SP][SL] &&
         (!HAS_RW_FILTER || f[FLT_RW_LSB +: 2] == RW_BOTH) |=> MON_HIT[k])
         else $error("unfiltered traffic not counted");

      // Both enables and both fields equal
      a_full_match: assert property (
         TXN_VALID && int'(TXN_SPACE) == SP && s_r.mge[SP][SL] &&
         s_r.mpe[SP][SL] && TXN_PERF_GROUP == f[23:16] &&
         TXN_PARTITION_ID == f[15:0] &&
         (!HAS_RW_FILTER || f[FLT_RW_LSB +: 2] == RW_BOTH) |=> MON_HIT[k])
         else $error("matching traffic not counted");
   end
endmodule
`default_nettype wire

// ===== bench/bwm_filter_bank_tb.sv
// Self-checking bench for the banked filter and selector block
`timescale 1ns/10ps
`default_nettype none
module bwm_filter_bank_tb;
   import bwm_pkg::*;
   localparam logic [11:0] SEL = OFS_SELECTOR;
   localparam logic [11:0] FLT = OFS_FILTER;
   localparam logic [11:0] CTL = OFS_CONTROL;
   logic CLK = 0, NRST = 0, REQ = 0, REQ_WE = 0, RSP_VALID, RSP_ERR;
   logic TXN_VALID = 0, TXN_IS_WRITE = 0;
   logic [1:0] REQ_SPACE = '0, TXN_SPACE = '0;
   logic [11:0] REQ_ADDR = '0;
   logic [31:0] REQ_WDATA = '0, RSP_DATA, MON_HIT;
   logic [15:0] TXN_PARTITION_ID = '0;
   logic [7:0] TXN_PERF_GROUP = '0;
   logic [31:0] m_sel[4] = '{default: '0};
   logic [31:0] m_flt[32] = '{default: '0};
   logic [31:0] m_ctl[32] = '{default: '0};
   int err_total = 0, checks = 0;
   bwm_filter_bank #(.MONITOR_COUNT(4), .RESOURCE_COUNT(2)) dut (.CLK(CLK),
      .NRST(NRST), .REQ(REQ), .REQ_WE(REQ_WE), .REQ_SPACE(REQ_SPACE),
      .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .RSP_VALID(RSP_VALID),
      .RSP_DATA(RSP_DATA), .RSP_ERR(RSP_ERR), .TXN_VALID(TXN_VALID),
      .TXN_SPACE(TXN_SPACE), .TXN_IS_WRITE(TXN_IS_WRITE),
      .TXN_PARTITION_ID(TXN_PARTITION_ID),
      .TXN_PERF_GROUP(TXN_PERF_GROUP), .MON_HIT(MON_HIT));
   logic L_RSP_VALID, L_RSP_ERR;
   logic [31:0] L_RSP_DATA, L_MON_HIT;
   // Cut-down build: no read/write filter, no realm extension
   bwm_filter_bank #(.MONITOR_COUNT(4), .RESOURCE_COUNT(2),
      .HAS_RW_FILTER(1'b0), .HAS_REALM_EXT(1'b0)) dut_lite (.CLK(CLK),
      .NRST(NRST), .REQ(REQ), .REQ_WE(REQ_WE), .REQ_SPACE(REQ_SPACE),
      .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .RSP_VALID(L_RSP_VALID),
      .RSP_DATA(L_RSP_DATA), .RSP_ERR(L_RSP_ERR), .TXN_VALID(TXN_VALID),
      .TXN_SPACE(TXN_SPACE), .TXN_IS_WRITE(TXN_IS_WRITE),
      .TXN_PARTITION_ID(TXN_PARTITION_ID),
      .TXN_PERF_GROUP(TXN_PERF_GROUP), .MON_HIT(L_MON_HIT));
   initial begin
      forever #5 CLK = ~CLK;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic idle();
      REQ = 0;
      TXN_VALID = 0;
      @(negedge CLK);
      chk({31'h0, RSP_VALID}, 32'h0);
      chk(MON_HIT, 32'h0);
   endtask
   // Register access, expectation from the local register model
   task automatic acc(input logic we, input logic [1:0] sp,
         input logic [11:0] a, input logic [31:0] d);
      int s;
      logic oob;
      logic [31:0] ed;
      s = 8 * int'(sp) + 4 * int'(m_sel[sp][27:24]) + int'(m_sel[sp][15:0]);
      oob = (a == FLT || a == CTL) && (m_sel[sp][15:0] >= 16'h0004
         || m_sel[sp][27:24] >= 4'h2);
      ed = 32'h0000_0000;
      if (!we && a == SEL) ed = m_sel[sp];
      if (!we && !oob && a == FLT) ed = m_flt[s];
      if (!we && !oob && a == CTL) ed = m_ctl[s];
      REQ = 1;
      REQ_WE = we;
      REQ_SPACE = sp;
      REQ_ADDR = a;
      REQ_WDATA = d;
      @(negedge CLK);
      chk({31'h0, RSP_VALID}, 32'h1);
      chk(RSP_DATA, ed);
      chk({31'h0, RSP_ERR}, {31'h0, oob});
      if (we && a == SEL) m_sel[sp] = d & SEL_MASK_RES;
      if (we && !oob && a == FLT) m_flt[s] = d & FLT_MASK_RW;
      if (we && !oob && a == CTL) m_ctl[s] = d & 32'h0003_0000;
   endtask
   // Traffic label, expected hits of all slots of that space
   task automatic txn(input logic [1:0] sp, input logic wr,
         input logic [15:0] p, input logic [7:0] g);
      logic [31:0] e;
      logic [1:0] c;
      int s;
      e = 32'h0000_0000;
      for (int i = 0; i < 8; i++) begin
         s = 8 * int'(sp) + i;
         c = m_flt[s][31:30];
         e[s] = (c == RW_BOTH || (c == RW_WRITE_ONLY && wr)
            || (c == RW_READ_ONLY && !wr))
            && (!m_ctl[s][17] || m_flt[s][23:16] == g)
            && (!m_ctl[s][16] || m_flt[s][15:0] == p);
      end
      TXN_VALID = 1;
      TXN_SPACE = sp;
      TXN_IS_WRITE = wr;
      TXN_PARTITION_ID = p;
      TXN_PERF_GROUP = g;
      @(negedge CLK);
      chk(MON_HIT, e);
   endtask
   task automatic t_banks();
      for (int sp = 0; sp < 4; sp++) begin
         acc(0, 2'(sp), SEL, 32'h0);
         acc(0, 2'(sp), FLT, 32'h0);
         acc(1, 2'(sp), SEL, 32'h0100_0001);
         acc(1, 2'(sp), FLT, 32'h4000_A000 + 32'(sp));
      end
      for (int sp = 0; sp < 4; sp++) begin
         acc(0, 2'(sp), FLT, 32'h0);
         acc(0, 2'(sp), SEL, 32'h0);
         txn(2'(sp), 1'b0, 16'h0000, 8'h00);
      end
      idle();
   endtask
   task automatic t_mask();
      acc(1, 0, SEL, 32'hFFFF_FFFF);
      acc(0, 0, SEL, 32'h0);
      acc(1, 0, FLT, 32'h1234_5678);
      acc(0, 0, FLT, 32'h0);
      acc(1, 0, SEL, 32'h0000_0004);
      acc(0, 0, CTL, 32'h0);
      acc(1, 0, SEL, 32'h0100_0003);
      acc(1, 0, FLT, 32'hFFFF_FFFF);
      acc(0, 0, FLT, 32'h0);
      acc(1, 0, CTL, 32'hFFFF_FFFF);
      acc(0, 0, CTL, 32'h0);
      acc(1, 0, 12'h824, 32'hFFFF_FFFF);
      acc(0, 0, 12'h824, 32'h0);
      txn(0, 1'b1, 16'hFFFF, 8'hFF);
      idle();
   endtask
   // Select, configure, then count, as software would
   task automatic t_match();
      acc(1, 1, SEL, 32'h0000_0002);
      for (int c = 0; c < 4; c++) begin
         for (int e = 0; e < 4; e++) begin
            acc(1, 1, FLT, {2'(c), 14'h005A, 16'h1234});
            acc(1, 1, CTL, 32'(e) << 16);
            for (int t = 0; t < 4; t++) begin
               txn(1, t[0], 16'h1234 + 16'(t == 2),
                  8'h5A + 8'(t == 3));
            end
         end
      end
      idle();
   endtask
   // Cut-down build beside the full one, same stimulus
   task automatic t_lite();
      acc(1, 0, SEL, 32'h0000_0000);
      acc(1, 0, FLT, 32'hFFFF_FFFF);
      acc(0, 0, FLT, 32'h0);
      chk(L_RSP_DATA, FLT_MASK_NO_RW);
      acc(1, 2, SEL, 32'h0000_0001);
      chk(L_RSP_DATA, 32'h0);
      acc(1, 2, FLT, 32'hFFFF_FFFF);
      acc(0, 2, FLT, 32'h0);
      chk(L_RSP_DATA, 32'h0);
      chk({31'h0, L_RSP_ERR}, 32'h0);
      txn(2, 1'b0, 16'h0000, 8'h00);
      chk(L_MON_HIT, 32'h00FF_0000);
      idle();
   endtask
   task automatic results();
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(negedge CLK);
      NRST = 1;
      idle();
      t_banks();
      t_mask();
      t_match();
      t_lite();
      results();
   end
   initial begin
      repeat (5000) @(posedge CLK);
      err_total++;
      results();
   end
endmodule
`default_nettype wire
